// ---- dv/testbench.sv ----
// testbench: self-checking axi4-lite bench for the peripheral reset bank
`timescale 1ns/1ps
module testbench;
    // ------------------------------------------------------------
    // stimulus, observed outputs and bench model
    // ------------------------------------------------------------
    logic aclk = 1'b0, aresetn = 1'b0; // reset held from time zero
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h00000000, cap = 32'hFFFFFFFF; // every unit present
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    wire [8:0] outs; // phy, mac, ports g down to a
    logic [31:0] sh = 32'h00000000; // what the control word should hold
    logic [33:0] rq[$]; // expected {rresp, rdata}, oldest first
    logic [10:0] bq[$]; // expected {bresp, reset outputs}, oldest first
    int err_count = 0, cmp_count = 0, seed = 32'h9B35;
    // writable bits worked out from the bit positions, not from the package mask
    localparam logic [31:0] IMPL = (32'h1 << 30) | (32'h1 << 28) | 32'h0000007F;
    localparam logic [11:0] CTRL = prs_pkg::PRS_ADDR_RESET_CTRL2;
    localparam logic [11:0] CAPV = prs_pkg::PRS_ADDR_CAP_WORD4;

    prs_reset_bank u_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .capability_word_four(cap), .ethernet_phy_reset(outs[8]), .ethernet_mac_reset(outs[7]),
        .port_g_reset(outs[6]), .port_f_reset(outs[5]), .port_e_reset(outs[4]),
        .port_d_reset(outs[3]), .port_c_reset(outs[2]), .port_b_reset(outs[1]),
        .port_a_reset(outs[0]));

    // ------------------------------------------------------------
    // clock, compare tasks and closing
    // ------------------------------------------------------------
    // 25 MHz system clock
    initial begin
        forever #20 aclk = ~aclk;
    end
    task automatic chk_rd(input logic [33:0] got, input logic [33:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t read got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_b(input logic [10:0] got, input logic [10:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t write got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // bus master tasks: note the expectation, then run the transfer
    // ------------------------------------------------------------
    // merge byte lanes into the old word, then keep only present writable units
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] m;
        m = sh;
        for (int k = 0; k < 4; k++) if (s[k]) m[k*8 +: 8] = d[k*8 +: 8];
        if (a == CTRL) sh = m & cap & IMPL;
        bq.push_back({(a == CTRL) ? prs_pkg::PRS_RESP_OKAY : prs_pkg::PRS_RESP_SLVERR,
                      sh[30], sh[28], sh[6:0]});
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // each half drops once taken; bready stays up until bvalid is seen
        do begin
            @(posedge aclk);
            awvalid <= awvalid && !awready;
            wvalid <= wvalid && !wready;
        end while (!bvalid);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a);
        rq.push_back((a == CTRL) ? {prs_pkg::PRS_RESP_OKAY, sh} :
                     (a == CAPV) ? {prs_pkg::PRS_RESP_OKAY, cap} :
                     {prs_pkg::PRS_RESP_SLVERR, 32'h00000000});
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            arvalid <= arvalid && !arready;
        end while (!rvalid);
        rready <= 1'b0;
    endtask

    // monitor: every handshake takes the oldest note off its queue
    always @(posedge aclk) begin
        if (aresetn && rvalid && rready) begin
            chk_rd({rresp, rdata}, rq.pop_front());
        end
        if (aresetn && bvalid && bready) begin
            chk_b({bresp, outs}, bq.pop_front());
        end
    end

    // watchdog: the sequence needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge aclk);
        $display("watchdog expired");
        err_count++;
        tally_and_finish();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd(CTRL);
        rd(CAPV);
        wr(12'h100, 32'hFFFFFFFF, 4'hF); // unmapped write must leave every unit out of reset
        rd(12'h100);
        $display("test reset_values done");
        // a single one walks across all positions, reserved ones included
        for (int i = 0; i < 32; i++) begin
            wr(CTRL, 32'h1 << i, 4'hF);
            rd(CTRL);
        end
        wr(CAPV, 32'hFFFFFFFF, 4'hF); // capability view is read only
        rd(CTRL);
        $display("test walking_bits done");
        // random capability, data and strobes through read-modify-write updates;
        // only implemented bits are flipped, reserved bits go back as they were read
        repeat (40) begin
            cap <= $random(seed);
            @(posedge aclk);
            rd(CTRL);
            wr(CTRL, sh ^ ($random(seed) & IMPL), 4'($random(seed)));
            rd(CAPV);
        end
        $display("test random_masking done");
        // a reset in mid-run drops every request
        cap <= 32'hFFFFFFFF;
        @(posedge aclk);
        wr(CTRL, 32'hFFFFFFFF, 4'hF);
        aresetn <= 1'b0;
        sh = 32'h00000000;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(CTRL);
        wr(12'h050, 32'h00000000, 4'hF);
        @(posedge aclk);
        $display("test mid_reset done");
        tally_and_finish();
    end
endmodule // testbench

// ---- hdl/prs_pkg.sv ----
// package: register map, field positions and reset values of the peripheral reset bank
package prs_pkg;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [11:0] PRS_ADDR_RESET_CTRL2 = 12'h048; // peripheral_reset_control_2
    localparam logic [11:0] PRS_ADDR_CAP_WORD4 = 12'h04C; // capability_word_four view
    localparam logic [31:0] PRS_RESET_CTRL2_RST = 32'h00000000; // value after reset
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int PRS_BIT_EPHY = 30; // ethernet_phy_reset
    localparam int PRS_BIT_EMAC = 28; // ethernet_mac_reset
    localparam int PRS_BIT_PORT_LSB = 0; // port_a_reset
    localparam int PRS_BIT_PORT_MSB = 6; // port_g_reset
    // implemented read/write bits; everything else is reserved and reads zero
    localparam logic [31:0] PRS_IMPL_MASK = 32'h5000007F;
    // axi response codes
    localparam logic [1:0] PRS_RESP_OKAY = 2'h0;
    localparam logic [1:0] PRS_RESP_SLVERR = 2'h2;
endpackage

// ---- hdl/prs_reset_bank.sv ----
// module: software reset control word for ethernet and port peripherals, axi4-lite slave
`timescale 1ns/1ps
// What this block does
// RULE1 - writes masked by capability word four bits
// RULE2 - bit 30 resets ethernet phy, clears
// RULE3 - bit 28 resets ethernet mac, clears
// RULE4 - bits 6..0 reset ports G..A, clear
// RULE5 - bits 31, 29, 27:7 read zero
// RULE6 - software preserves reserved bits via read-modify-write
// RULE7 - bit one holds unit reset, zero releases
module prs_reset_bank (
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // capability word: which peripherals exist (static strap-like input)
    input wire logic [31:0] capability_word_four,
    // reset requests to the peripherals, active high
    output logic ethernet_phy_reset,
    output logic ethernet_mac_reset,
    output logic port_a_reset,
    output logic port_b_reset,
    output logic port_c_reset,
    output logic port_d_reset,
    output logic port_e_reset,
    output logic port_f_reset,
    output logic port_g_reset
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [31:0] ctrl_r; // peripheral_reset_control_2 contents
    logic [11:0] awaddr_r; // captured write address
    logic aw_held_r; // write address taken, waiting for data
    logic [31:0] wdata_r; // captured write data
    logic [3:0] wstrb_r; // captured byte strobes
    logic w_held_r; // write data taken, waiting for address
    logic bvalid_r; // write response pending
    logic [1:0] bresp_r; // write response code
    logic rvalid_r; // read data pending
    logic [31:0] rdata_r; // read data register
    logic [1:0] rresp_r; // read response code
    logic [31:0] ctrl_nxt; // merged value for a write

    // byte-strobe merge, used for the one writable register
    function automatic logic [31:0] prs_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // ----------------------------------------------------------------
    // write channel
    // ----------------------------------------------------------------
    // each channel is accepted independently; ready drops while the item is held
    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready = !w_held_r && !bvalid_r;

    // address capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            awaddr_r <= 12'h000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
        end else if (aw_held_r && w_held_r) begin
            aw_held_r <= 1'b0; // consumed by the register write
        end
    end

    // data capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_r <= 1'b0;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
        end else if (aw_held_r && w_held_r) begin
            w_held_r <= 1'b0;
        end
    end

    // new control value: strobe merge, then capability gate, then reserved clear
    always_comb begin
        ctrl_nxt = prs_merge(ctrl_r, wdata_r, wstrb_r);
        // absent units cannot be set, whatever software writes
        ctrl_nxt = ctrl_nxt & capability_word_four; // RULE1
        ctrl_nxt = ctrl_nxt & prs_pkg::PRS_IMPL_MASK; // RULE5
    end

    // control register; software is expected to read-modify-write it, reserved bits read zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= prs_pkg::PRS_RESET_CTRL2_RST; // RULE2 RULE3 RULE4
        end else if (aw_held_r && w_held_r && awaddr_r == prs_pkg::PRS_ADDR_RESET_CTRL2) begin
            ctrl_r <= ctrl_nxt; // RULE2 RULE3 RULE4
        end
    end

    // write response, one cycle after both halves are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= prs_pkg::PRS_RESP_OKAY;
        end else if (aw_held_r && w_held_r) begin
            bvalid_r <= 1'b1;
            // the capability view is read-only: writes to it are refused
            if (awaddr_r == prs_pkg::PRS_ADDR_RESET_CTRL2) begin
                bresp_r <= prs_pkg::PRS_RESP_OKAY;
            end else begin
                bresp_r <= prs_pkg::PRS_RESP_SLVERR;
            end
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    // ----------------------------------------------------------------
    // read channel
    // ----------------------------------------------------------------
    // one read at a time; address is refused while data waits
    assign s_axi_arready = !rvalid_r;

    // read decode and data capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= prs_pkg::PRS_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_r <= 1'b1;
            if (s_axi_araddr == prs_pkg::PRS_ADDR_RESET_CTRL2) begin
                rdata_r <= ctrl_r & prs_pkg::PRS_IMPL_MASK; // RULE5
                rresp_r <= prs_pkg::PRS_RESP_OKAY;
            end else if (s_axi_araddr == prs_pkg::PRS_ADDR_CAP_WORD4) begin
                rdata_r <= capability_word_four;
                rresp_r <= prs_pkg::PRS_RESP_OKAY;
            end else begin
                // unmapped: zero data with slave error
                rdata_r <= 32'h00000000;
                rresp_r <= prs_pkg::PRS_RESP_SLVERR;
            end
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // ----------------------------------------------------------------
    // reset request outputs
    // ----------------------------------------------------------------
    // level outputs straight from the register: held while one, released at zero
    assign ethernet_phy_reset = ctrl_r[prs_pkg::PRS_BIT_EPHY]; // RULE2 RULE7
    assign ethernet_mac_reset = ctrl_r[prs_pkg::PRS_BIT_EMAC]; // RULE3 RULE7
    assign port_a_reset = ctrl_r[prs_pkg::PRS_BIT_PORT_LSB]; // RULE4 RULE7
    assign port_b_reset = ctrl_r[prs_pkg::PRS_BIT_PORT_LSB + 1]; // RULE4
    assign port_c_reset = ctrl_r[prs_pkg::PRS_BIT_PORT_LSB + 2]; // RULE4
    assign port_d_reset = ctrl_r[prs_pkg::PRS_BIT_PORT_LSB + 3]; // RULE4
    assign port_e_reset = ctrl_r[prs_pkg::PRS_BIT_PORT_LSB + 4]; // RULE4
    assign port_f_reset = ctrl_r[prs_pkg::PRS_BIT_PORT_LSB + 5]; // RULE4
    assign port_g_reset = ctrl_r[prs_pkg::PRS_BIT_PORT_MSB]; // RULE4

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    logic wr_fire; // a write to the control word completes this cycle
    assign wr_fire = aw_held_r && w_held_r && awaddr_r == prs_pkg::PRS_ADDR_RESET_CTRL2;

    sequence s_wr_commit;
        wr_fire ##1 bvalid_r;
    endsequence

    a_cap_gates_write: assert property (@(posedge aclk) disable iff (!aresetn) // RULE1
        wr_fire |=> (ctrl_r & ~$past(capability_word_four)) == 32'h00000000)
        else $error("control bit set for absent unit");
    a_phy_bit_write: assert property (@(posedge aclk) disable iff (!aresetn) // RULE2
        wr_fire && wstrb_r[3] |=> ethernet_phy_reset ==
            ($past(wdata_r[30]) && $past(capability_word_four[30])))
        else $error("phy reset does not follow write");
    a_mac_bit_write: assert property (@(posedge aclk) disable iff (!aresetn) // RULE3
        wr_fire && wstrb_r[3] |=> ethernet_mac_reset ==
            ($past(wdata_r[28]) && $past(capability_word_four[28])))
        else $error("mac reset does not follow write");
    a_port_bits_write: assert property (@(posedge aclk) disable iff (!aresetn) // RULE4
        wr_fire && wstrb_r[0] |=> ctrl_r[6:0] ==
            ($past(wdata_r[6:0]) & $past(capability_word_four[6:0])))
        else $error("port reset bits do not follow write");
    a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn) // RULE5
        (ctrl_r & ~prs_pkg::PRS_IMPL_MASK) == 32'h00000000)
        else $error("reserved control bit set");
    a_read_masked: assert property (@(posedge aclk) disable iff (!aresetn) // RULE5
        s_axi_arvalid && s_axi_arready && s_axi_araddr == prs_pkg::PRS_ADDR_RESET_CTRL2
        |=> rvalid_r && rdata_r[31] == 1'b0 && rdata_r[29] == 1'b0 && rdata_r[27:7] == 21'h0)
        else $error("reserved bits read nonzero");
    a_hold_no_write: assert property (@(posedge aclk) disable iff (!aresetn) // RULE7
        !wr_fire |=> $stable(ctrl_r))
        else $error("reset request changed without a write");
    a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn) // RULE7
        s_wr_commit |-> bresp_r == prs_pkg::PRS_RESP_OKAY)
        else $error("control write not answered okay");
    a_reset_clears: assert property (@(posedge aclk) // RULE2
        !aresetn |=> ctrl_r == prs_pkg::PRS_RESET_CTRL2_RST)
        else $error("control word not cleared by reset");

    // both halves of a write held: the commit step of every write
    sequence s_both_held;
        aw_held_r && w_held_r;
    endsequence

    // an accepted read address
    sequence s_rd_accept;
        s_axi_arvalid && s_axi_arready;
    endsequence

    // a write answer that the master has not taken yet
    sequence s_b_waiting;
        bvalid_r && !s_axi_bready;
    endsequence

    // a read answer that the master has not taken yet
    sequence s_r_waiting;
        rvalid_r && !s_axi_rready;
    endsequence

    // commit empties both holding stages and raises the answer at one edge
    a_commit_answers: assert property (@(posedge aclk) disable iff (!aresetn) // RULE7
        s_both_held |=> bvalid_r && !aw_held_r && !w_held_r)
        else $error("write commit did not raise the response");
    // a pending write answer must not vanish or change before it is taken
    a_b_holds: assert property (@(posedge aclk) disable iff (!aresetn) // RULE1
        s_b_waiting |=> bvalid_r && $stable(bresp_r))
        else $error("write response dropped before bready");
    a_b_drops: assert property (@(posedge aclk) disable iff (!aresetn) // RULE1
        bvalid_r && s_axi_bready |=> !bvalid_r)
        else $error("write response not retired after bready");
    // a second write half is refused while one is held or answered
    a_aw_refused: assert property (@(posedge aclk) disable iff (!aresetn) // RULE1
        aw_held_r || bvalid_r |-> !s_axi_awready)
        else $error("write address accepted while busy");
    a_w_refused: assert property (@(posedge aclk) disable iff (!aresetn) // RULE1
        w_held_r || bvalid_r |-> !s_axi_wready)
        else $error("write data accepted while busy");
    // a read is answered at the very next edge
    a_rd_answers: assert property (@(posedge aclk) disable iff (!aresetn) // RULE5
        s_rd_accept |=> rvalid_r)
        else $error("read not answered in one cycle");
    a_r_holds: assert property (@(posedge aclk) disable iff (!aresetn) // RULE5
        s_r_waiting |=> rvalid_r && $stable(rdata_r) && $stable(rresp_r))
        else $error("read data changed before rready");
    a_r_drops: assert property (@(posedge aclk) disable iff (!aresetn) // RULE5
        rvalid_r && s_axi_rready |=> !rvalid_r)
        else $error("read data not retired after rready");
    a_ar_refused: assert property (@(posedge aclk) disable iff (!aresetn) // RULE5
        rvalid_r |-> !s_axi_arready)
        else $error("read address accepted while data waits");
    // the capability view shows the input word as sampled at the accept edge
    a_cap_view: assert property (@(posedge aclk) disable iff (!aresetn) // RULE1
        s_axi_arvalid && s_axi_arready && s_axi_araddr == prs_pkg::PRS_ADDR_CAP_WORD4
        |=> rdata_r == $past(capability_word_four) && rresp_r == prs_pkg::PRS_RESP_OKAY)
        else $error("capability view read wrong");
    // unmapped reads return zero with an error code
    a_unmapped_error: assert property (@(posedge aclk) disable iff (!aresetn) // RULE5
        s_axi_arvalid && s_axi_arready && s_axi_araddr != prs_pkg::PRS_ADDR_RESET_CTRL2
            && s_axi_araddr != prs_pkg::PRS_ADDR_CAP_WORD4
        |=> rresp_r == prs_pkg::PRS_RESP_SLVERR && rdata_r == 32'h00000000)
        else $error("unmapped read not refused");
    // writing zero releases the unit at the commit edge
    a_release_on_zero: assert property (@(posedge aclk) disable iff (!aresetn) // RULE7
        wr_fire && wstrb_r[3] && !wdata_r[28] |=> !ethernet_mac_reset)
        else $error("mac reset not released by a zero write");
    a_ports_release: assert property (@(posedge aclk) disable iff (!aresetn) // RULE7
        wr_fire && wstrb_r[0] && wdata_r[6:0] == 7'h00
        |=> {port_g_reset, port_f_reset, port_e_reset, port_d_reset, port_c_reset,
            port_b_reset, port_a_reset} == 7'h00)
        else $error("port resets not released by a zero write");
    // after a reset edge the bus is idle and every channel is ready
    a_ready_after_reset: assert property (@(posedge aclk) // RULE2
        !aresetn |=> s_axi_awready && s_axi_wready && s_axi_arready
            && !s_axi_bvalid && !s_axi_rvalid)
        else $error("bus not idle after reset");
    // no peripheral is held in reset after a system reset
    a_outputs_cleared: assert property (@(posedge aclk) // RULE4
        !aresetn |=> {ethernet_phy_reset, ethernet_mac_reset, port_g_reset, port_f_reset,
            port_e_reset, port_d_reset, port_c_reset, port_b_reset, port_a_reset} == 9'h000)
        else $error("reset request outputs not cleared by reset");

endmodule // prs_reset_bank
